// ===== logic/bsspi_pkg.sv
// Constants shared by the split-port burst memory interface
package bsspi_pkg;
    localparam int WORD_W       = 18;   // Port width
    localparam int LANE_W       = 9;    // Bits per byte lane
    localparam int LANES        = 2;    // Byte lanes per word
    localparam int BURST        = 4;    // Words per access
    localparam int ADDR_W       = 20;   // Address bits, one address per burst
    localparam int LAT_LOOP     = 5;    // Link edges, 2.5 cycles
    localparam int LAT_BYPASS   = 2;    // Link edges, 1 cycle
    localparam int IMP_PERIOD   = 1024; // Positive-clock cycles
    localparam int CLK_MHZ      = 200;
    localparam int LOCK_US      = 20;
    localparam int STOP_NS      = 30;
    localparam int LOCK_CYC     = LOCK_US * CLK_MHZ;
    localparam int STOP_CYC     = (STOP_NS * CLK_MHZ + 999) / 1000;
    localparam logic RST_OE     = 1'b0;
    localparam logic RST_RANGE  = 1'b1; // High range when floating
endpackage : bsspi_pkg

// ===== logic/bsspi_core.sv
// Split-port burst memory device: link-side ports, array and loop status
`timescale 1ns/10ps
// What this block does
// - Read select low on a positive rise captures the read address.
// - Each access moves four sequential words over two clock cycles.
// - First read word follows two positive rises with the loop on, one in bypass, then one word per edge.
// - A read on consecutive positive rises is dropped; alternate rises stream.
// - Deselected read port finishes bursts, then floats after a complementary rise.
// - Write select low on a positive rise latches the write address.
// - Write words captured on four following edges, then burst committed.
// - A write on consecutive positive rises is dropped; alternate rises stream.
// - Deselected write port finishes its burst, then ignores its inputs.
// - Active-low lane masks sampled per word; masked lanes keep stored data.
// - Reads after writes to the same location return the newest data.
// - Both selects from idle: read wins.
// - Both selects: write wins after a read, read wins after a write.
// - Both selects held from idle alternate, read first.
// - Selects sampled on positive rises only; only one port is granted per rise.
// - Output impedance updated once every 1024 clock cycles.
// - Two free-running echo clocks, one per input clock phase.
// - Read-valid flag rises half a cycle before the first word.
// - Termination range strap caught at start-up: low picks low range.
// - Loop locks 20 us after a stable clock when enabled.
// - Clock stopped or slowed for 30 ns resets the loop.
// - Bypass low disables the loop and gives one-cycle read latency.
// - With the loop on, read latency is two and a half cycles.
// - After power-up both ports idle and read outputs float.
module bsspi_core #(
    parameter int ADDR_W   = bsspi_pkg::ADDR_W,
    parameter int LOCK_CYC = bsspi_pkg::LOCK_CYC,
    parameter int STOP_CYC = bsspi_pkg::STOP_CYC
) (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          link_clk,
    input  wire logic                          read_port_select_n,
    input  wire logic                          write_port_select_n,
    input  wire logic [ADDR_W-1:0]             address,
    input  wire logic [bsspi_pkg::WORD_W-1:0]  write_data,
    input  wire logic [bsspi_pkg::LANES-1:0]   byte_lane_write_mask_n,
    input  wire logic                          loop_bypass_n,
    input  wire logic                          termination_range_select,
    output logic      [bsspi_pkg::WORD_W-1:0]  read_data,
    output logic                               read_data_oe,
    output logic                               read_valid_flag,
    output logic                               echo_clock,
    output logic                               echo_clock_n,
    output logic                               impedance_update,
    output logic                               loop_locked,
    output logic                               termination_high_range
);
    localparam int W  = bsspi_pkg::WORD_W;
    localparam int LW = bsspi_pkg::LANE_W;
    localparam int NL = bsspi_pkg::LANES;
    localparam int IW = $clog2(bsspi_pkg::IMP_PERIOD);
    localparam int LCW = $clog2(LOCK_CYC + 1);
    localparam int GCW = $clog2(STOP_CYC + 1);

    if (ADDR_W < 1 || ADDR_W > 24 || LOCK_CYC < 1 || STOP_CYC < 1) begin : g_chk
        $error("bsspi_core: unsupported parameter value");
    end

    // Link-side reset: async assert, release synchronised to the link clock
    logic lrst_s1_q, lrst_n_q;
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_q <= 1'b0;
            lrst_n_q  <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_n_q  <= lrst_s1_q;
        end
    end

    // Bypass pin is static but asynchronous; two flops before use.
    // Held by the pin reset only, so the mode settles before the first K rise
    logic byp_s1_q, mode_loop_q;
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_s1_q    <= 1'b0;
            mode_loop_q <= 1'b0;
        end else begin
            byp_s1_q    <= loop_bypass_n;
            mode_loop_q <= byp_s1_q;
        end
    end

    // Each link edge is one data edge; phase 0 is a positive-clock rise
    logic phase_q, is_k;
    assign is_k = !phase_q;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) phase_q <= 1'b0;
        else           phase_q <= !phase_q;
    end

    // Arbitration: selects looked at on positive rises only
    logic rd_req, wr_req, grant_rd, grant_wr, last_rd_q, last_wr_q;
    assign rd_req   = is_k && !read_port_select_n;
    assign wr_req   = is_k && !write_port_select_n;
    assign grant_rd = rd_req && !last_rd_q;
    assign grant_wr = wr_req && !last_wr_q && !grant_rd;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            last_rd_q <= 1'b0;
            last_wr_q <= 1'b0;
        end else if (is_k) begin
            last_rd_q <= grant_rd;
            last_wr_q <= grant_wr;
        end
    end

    // Read request delay line; spacing of four edges keeps bursts apart
    logic [bsspi_pkg::LAT_LOOP-1:0] rd_v_q;
    logic [ADDR_W-1:0]              rd_a_q [bsspi_pkg::LAT_LOOP];
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rd_v_q <= '0;
            for (int i = 0; i < bsspi_pkg::LAT_LOOP; i++) rd_a_q[i] <= '0;
        end else begin
            rd_v_q    <= {rd_v_q[bsspi_pkg::LAT_LOOP-2:0], grant_rd};
            rd_a_q[0] <= address;
            for (int i = 1; i < bsspi_pkg::LAT_LOOP; i++) rd_a_q[i] <= rd_a_q[i-1];
        end
    end

    // Latency tap chosen by loop mode
    logic go, pre;
    logic [ADDR_W-1:0] go_a;
    always_comb begin
        if (mode_loop_q) begin
            go   = rd_v_q[bsspi_pkg::LAT_LOOP-1];
            pre  = rd_v_q[bsspi_pkg::LAT_LOOP-2];
            go_a = rd_a_q[bsspi_pkg::LAT_LOOP-1];
        end else begin
            go   = rd_v_q[bsspi_pkg::LAT_BYPASS-1];
            pre  = rd_v_q[bsspi_pkg::LAT_BYPASS-2];
            go_a = rd_a_q[bsspi_pkg::LAT_BYPASS-1];
        end
    end

    // Read burst sequencer
    logic              ract_q;
    logic [1:0]        rbeat_q;
    logic [ADDR_W-1:0] raddr_q;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            ract_q  <= 1'b0;
            rbeat_q <= 2'h0;
            raddr_q <= '0;
        end else if (go) begin
            ract_q  <= 1'b1;
            rbeat_q <= 2'h1;
            raddr_q <= go_a;
        end else if (ract_q) begin
            rbeat_q <= rbeat_q + 2'h1;
            if (rbeat_q == 2'h3) ract_q <= 1'b0;
        end
    end

    // Write address holds until its data starts on the next positive rise
    logic              wpend_q, wact_q, wstart;
    logic [1:0]        wbeat_q, cbeat;
    logic [ADDR_W-1:0] wpaddr_q, waddr_q;
    logic [W-1:0]      wdat_q [bsspi_pkg::BURST];
    logic [NL-1:0]     wben_q [bsspi_pkg::BURST];
    assign wstart = is_k && wpend_q;
    assign cbeat  = wstart ? 2'h0 : wbeat_q;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            wpend_q  <= 1'b0;
            wpaddr_q <= '0;
        end else if (grant_wr) begin
            wpend_q  <= 1'b1;
            wpaddr_q <= address;
        end else if (is_k) begin
            wpend_q  <= 1'b0;
        end
    end

    // Write beat capture; data and masks taken on every edge of a burst
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            wact_q  <= 1'b0;
            wbeat_q <= 2'h0;
            waddr_q <= '0;
            for (int k = 0; k < bsspi_pkg::BURST; k++) begin
                wdat_q[k] <= '0;
                wben_q[k] <= '0;
            end
        end else if (wstart || wact_q) begin
            wact_q  <= !(wact_q && wbeat_q == 2'h3);
            wbeat_q <= cbeat + 2'h1;
            if (wstart) begin
                waddr_q <= wpaddr_q;
                for (int k = 1; k < bsspi_pkg::BURST; k++) wben_q[k] <= '0;
            end
            wdat_q[cbeat] <= write_data;
            wben_q[cbeat] <= ~byte_lane_write_mask_n;
            if (wact_q && wbeat_q == 2'h3) begin
                for (int k = 0; k < bsspi_pkg::BURST; k++) wben_q[k] <= '0;
            end
        end
    end

    // Array: the burst is written whole on its last beat
    logic [W*bsspi_pkg::BURST-1:0] mem_q [2**ADDR_W];
    logic                          commit;
    assign commit = wact_q && wbeat_q == 2'h3;
    always_ff @(posedge link_clk) begin
        if (commit) begin
            for (int k = 0; k < bsspi_pkg::BURST; k++) begin
                for (int l = 0; l < NL; l++) begin
                    if (k == bsspi_pkg::BURST - 1 ? !byte_lane_write_mask_n[l] : wben_q[k][l]) begin
                        mem_q[waddr_q][k*W + l*LW +: LW] <=
                            (k == bsspi_pkg::BURST - 1) ? write_data[l*LW +: LW] : wdat_q[k][l*LW +: LW];
                    end
                end
            end
        end
    end

    // Read word fetch with forwarding from a burst still being assembled
    logic [ADDR_W-1:0] sel_a;
    logic [1:0]        sel_k;
    logic [W-1:0]      arr_w, fwd_w;
    logic              hit;
    logic [W*bsspi_pkg::BURST-1:0] rline_q;
    assign sel_a = go ? go_a : raddr_q;
    assign sel_k = go ? 2'h0 : rbeat_q;
    // With the loop on, a write granted after the read could commit before the
    // last beat; the line is frozen at the first beat, when older writes are done
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) rline_q <= '0;
        else if (go)   rline_q <= mem_q[go_a];
    end
    assign arr_w = (mode_loop_q && !go) ? rline_q[sel_k*W +: W] : mem_q[sel_a][sel_k*W +: W];
    assign hit   = !mode_loop_q && wact_q && waddr_q == sel_a;
    for (genvar l = 0; l < NL; l++) begin : g_fwd
        // Only lanes already captured and enabled override the array
        assign fwd_w[l*LW +: LW] = (hit && wben_q[sel_k][l]) ?
                                   wdat_q[sel_k][l*LW +: LW] : arr_w[l*LW +: LW];
    end

    // Read outputs; enable drops at a complementary rise once idle
    logic [W-1:0] rdata_q;
    logic         oe_q, vld_q, word_out;
    assign word_out = go || ract_q;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rdata_q <= '0;
            oe_q    <= bsspi_pkg::RST_OE;
            vld_q   <= 1'b0;
        end else begin
            if (word_out) rdata_q <= fwd_w;
            if (word_out)  oe_q <= 1'b1;
            else if (!is_k) oe_q <= 1'b0;
            vld_q <= pre || go || (ract_q && rbeat_q != 2'h3);
        end
    end
    assign read_data       = rdata_q;
    assign read_data_oe    = oe_q;
    assign read_valid_flag = vld_q;

    // Echo clocks and periodic impedance update
    logic          echo_q, echo_n_q, imp_q;
    logic [IW-1:0] imp_cnt_q;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            echo_q    <= 1'b0;
            echo_n_q  <= 1'b1;
            imp_cnt_q <= '0;
            imp_q     <= 1'b0;
        end else begin
            echo_q   <= is_k;
            echo_n_q <= !is_k;
            imp_q    <= is_k && imp_cnt_q == IW'(bsspi_pkg::IMP_PERIOD - 1);
            if (is_k) imp_cnt_q <= imp_cnt_q + IW'(1);
        end
    end
    assign echo_clock       = echo_q;
    assign echo_clock_n     = echo_n_q;
    assign impedance_update = imp_q;

    // Core side: link activity, bypass and strap brought in by two flops
    logic act_s1_q, act_s2_q, act_s3_q, cbyp_s1_q, cbyp_s2_q, st_s1_q, st_s2_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {act_s1_q, act_s2_q, act_s3_q} <= 3'h0;
            {cbyp_s1_q, cbyp_s2_q}         <= 2'h0;
            {st_s1_q, st_s2_q}             <= 2'h3;
        end else begin
            act_s1_q  <= phase_q;
            act_s2_q  <= act_s1_q;
            act_s3_q  <= act_s2_q;
            cbyp_s1_q <= loop_bypass_n;
            cbyp_s2_q <= cbyp_s1_q;
            st_s1_q   <= termination_range_select;
            st_s2_q   <= st_s1_q;
        end
    end

    // Loop lock model: a stalled or slow link clock restarts the count
    logic [GCW-1:0] gap_q;
    logic [LCW-1:0] lock_q;
    logic           locked_q, stopped;
    assign stopped = gap_q >= GCW'(STOP_CYC);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_q    <= '0;
            lock_q   <= '0;
            locked_q <= 1'b0;
        end else begin
            if (act_s2_q != act_s3_q) gap_q <= '0;
            else if (!stopped)        gap_q <= gap_q + GCW'(1);
            if (!cbyp_s2_q || stopped) lock_q <= '0;
            else if (lock_q != LCW'(LOCK_CYC)) lock_q <= lock_q + LCW'(1);
            locked_q <= cbyp_s2_q && !stopped && lock_q == LCW'(LOCK_CYC);
        end
    end
    assign loop_locked = locked_q;

    // Strap caught once, after the synchroniser holds a real pin value
    logic [1:0] st_wait_q;
    logic       st_done_q, range_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_wait_q <= 2'h0;
            st_done_q <= 1'b0;
            range_q   <= bsspi_pkg::RST_RANGE;
        end else begin
            st_wait_q <= {st_wait_q[0], 1'b1};
            if (st_wait_q[1] && !st_done_q) begin
                range_q   <= st_s2_q;
                st_done_q <= 1'b1;
            end
        end
    end
    assign termination_high_range = range_q;

    // Checks on the link side, plus the loop lock check on the core clock
    sequence s_burst_out;
        read_valid_flag ##1 read_data_oe [*4];
    endsequence
    property p_rd_loop;
        @(posedge link_clk) disable iff (!lrst_n_q)
        grant_rd && mode_loop_q |-> ##5 s_burst_out;
    endproperty
    a_rd_loop: assert property (p_rd_loop) else $error("loop read latency wrong");
    property p_rd_byp;
        @(posedge link_clk) disable iff (!lrst_n_q)
        grant_rd && !mode_loop_q |-> ##2 s_burst_out;
    endproperty
    a_rd_byp: assert property (p_rd_byp) else $error("bypass read latency wrong");
    property p_rd_space;
        @(posedge link_clk) disable iff (!lrst_n_q)
        grant_rd |-> ##2 !grant_rd;
    endproperty
    a_rd_space: assert property (p_rd_space) else $error("read on consecutive rises");
    property p_wr_space;
        @(posedge link_clk) disable iff (!lrst_n_q)
        grant_wr |-> ##2 !grant_wr;
    endproperty
    a_wr_space: assert property (p_wr_space) else $error("write on consecutive rises");
    property p_both;
        @(posedge link_clk) disable iff (!lrst_n_q)
        rd_req && wr_req |-> (last_rd_q ? grant_wr && !grant_rd : grant_rd && !grant_wr);
    endproperty
    a_both: assert property (p_both) else $error("same-edge arbitration wrong");
    property p_wr_burst;
        @(posedge link_clk) disable iff (!lrst_n_q)
        grant_wr |-> ##2 wstart ##3 commit ##1 !commit;
    endproperty
    a_wr_burst: assert property (p_wr_burst) else $error("write burst timing wrong");
    property p_hiz;
        @(posedge link_clk) disable iff (!lrst_n_q)
        read_data_oe && !is_k && !word_out && rd_v_q == '0 |=> !read_data_oe [*2];
    endproperty
    a_hiz: assert property (p_hiz) else $error("read outputs not floated");
    property p_echo;
        @(posedge link_clk) disable iff (!lrst_n_q)
        $past(lrst_n_q) |-> (echo_clock != echo_clock_n) ##1 $changed(echo_clock);
    endproperty
    a_echo: assert property (p_echo) else $error("echo clocks not running");
    property p_imp;
        @(posedge link_clk) disable iff (!lrst_n_q)
        impedance_update |=> !impedance_update [*8];
    endproperty
    a_imp: assert property (p_imp) else $error("impedance update too often");
    property p_lock;
        @(posedge clock) disable iff (!rst_n)
        $rose(loop_locked) |-> $past(lock_q) == LCW'(LOCK_CYC) && cbyp_s2_q;
    endproperty
    a_lock: assert property (p_lock) else $error("loop locked early");
endmodule // bsspi_core

// ===== bench/bsspi_ctrl_model.sv
// Memory controller model: selects, address and write beats per link edge
`timescale 1ns/10ps
module bsspi_ctrl_model #(
    parameter int ADDR_W = 6
) (
    input  wire logic          link_clk,
    input  wire logic          rst_n,
    output logic               read_port_select_n,
    output logic               write_port_select_n,
    output logic [ADDR_W-1:0]  address,
    output logic [17:0]        write_data,
    output logic [1:0]         byte_lane_write_mask_n,
    output int                 edge_cnt
);
    logic [1:0]        sel_at[int];
    logic [ADDR_W-1:0] adr_at[int];
    logic [17:0]       dat_at[int];
    logic [1:0]        msk_at[int];
    // Idle values at time zero
    initial begin
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        address = '0;
        write_data = 18'h00000;
        byte_lane_write_mask_n = 2'h3;
    end
    // Edge 3 after release is the first K rise
    always @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) edge_cnt <= 0;
        else edge_cnt <= edge_cnt + 1;
    end
    // Stale bookings would replay after a reset
    always @(negedge rst_n) begin
        sel_at.delete();
        adr_at.delete();
        dat_at.delete();
        msk_at.delete();
    end
    // Unbooked address, data and mask lines toggle and unbooked selects go high, so a stale value is never mistaken for data
    always @(negedge link_clk) begin
        int e;
        e = edge_cnt + 1;
        read_port_select_n <= !(sel_at.exists(e) && sel_at[e][1]);
        write_port_select_n <= !(sel_at.exists(e) && sel_at[e][0]);
        address <= adr_at.exists(e) ? adr_at[e] : ~address;
        write_data <= dat_at.exists(e) ? dat_at[e] : ~write_data;
        byte_lane_write_mask_n <= msk_at.exists(e) ? msk_at[e] : ~byte_lane_write_mask_n;
    end
    // Book a request on the first K rise two or more edges ahead; returns once that edge has passed
    task automatic issue(input logic rd, input logic wr, input logic wsched,
                         input logic [ADDR_W-1:0] a, input logic [71:0] d, input logic [7:0] m,
                         output int e0);
        e0 = edge_cnt + 2 + ((edge_cnt % 2 == 0) ? 1 : 0);
        sel_at[e0] = {rd, wr};
        adr_at[e0] = a;
        for (int i = 0; i < 4 && wsched; i++) begin
            dat_at[e0 + 2 + i] = d[18*i +: 18];
            msk_at[e0 + 2 + i] = m[2*i +: 2];
        end
        wait (edge_cnt >= e0);
    endtask
endmodule // bsspi_ctrl_model

// ===== bench/tb_top.sv
// Self-checking bench for the split-port burst memory device
`timescale 1ns/10ps
module tb_top;
    logic        clock = 1'b0;
    logic        link_clk = 1'b0;
    logic        link_run = 1'b1;
    logic        rst_n = 1'b0;
    logic        loop_bypass_n = 1'b1;
    logic        term_sel = 1'b1;
    logic        rps_n, wps_n, read_data_oe, read_valid_flag, echo_clock, echo_clock_n;
    logic        impedance_update, loop_locked, termination_high_range;
    logic [5:0]  address;
    logic [17:0] write_data, read_data;
    logic [1:0]  mask_n;
    logic [71:0] shadow[64];
    logic [17:0] exp_at[int];
    logic        last_rd, last_wr;
    int          edge_cnt, lat = 5, imp_last = 0, imp_seen = 0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #2.5 clock = ~clock;
    // Link clock offset so its edges never coincide with the core clock
    initial begin
        #13.1;
        forever #40 if (link_run) link_clk = ~link_clk;
    end
    bsspi_ctrl_model #(.ADDR_W(6)) u_bsspi_ctrl_model (.link_clk(link_clk), .rst_n(rst_n),
        .read_port_select_n(rps_n), .write_port_select_n(wps_n), .address(address),
        .write_data(write_data), .byte_lane_write_mask_n(mask_n), .edge_cnt(edge_cnt));
    bsspi_core #(.ADDR_W(6), .LOCK_CYC(50), .STOP_CYC(20)) u_bsspi_core (.clock(clock), .rst_n(rst_n),
        .link_clk(link_clk), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
        .address(address), .write_data(write_data), .byte_lane_write_mask_n(mask_n),
        .loop_bypass_n(loop_bypass_n), .termination_range_select(term_sel), .read_data(read_data),
        .read_data_oe(read_data_oe), .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
        .echo_clock_n(echo_clock_n), .impedance_update(impedance_update), .loop_locked(loop_locked),
        .termination_high_range(termination_high_range));
    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Per-edge view of read port, echo clocks and impedance pulses
    always @(negedge link_clk) begin
        int c;
        c = edge_cnt;
        if (rst_n && c >= 3) begin
            chk("echo", {echo_clock, echo_clock_n}, {c[0], ~c[0]});
            chk("flag", read_valid_flag, exp_at.exists(c + 1));
            if (exp_at.exists(c)) begin
                chk("oe", read_data_oe, 1'b1);
                chk("data", read_data, exp_at[c]);
            end else if (!c[0] || !exp_at.exists(c - 1))
                chk("oe idle", read_data_oe, 1'b0);
            if (impedance_update === 1'b1) begin
                if (imp_last > 0) chk("imp gap", c - imp_last, 2048);
                imp_last = c;
                imp_seen++;
            end
        end
    end
    // One K rise: arbitration, shadow array and expected read words
    task automatic req(input logic rd, input logic wr, input logic [5:0] a, input logic [71:0] d,
                       input logic [7:0] m);
        logic rg, wg;
        int e0;
        rg = rd && !last_rd;
        wg = wr && !last_wr && !rg;
        u_bsspi_ctrl_model.issue(rd, wr, wg, a, d, m, e0);
        last_rd = rg;
        last_wr = wg;
        for (int i = 0; i < 8; i++)
            if (wg && !m[i]) shadow[a][9*i +: 9] = d[9*i +: 9];
        for (int i = 0; i < 4; i++)
            if (rg) exp_at[e0 + lat + i] = shadow[a][18*i +: 18];
    endtask
    task automatic gap(input int n);
        repeat (n) req(1'b0, 1'b0, 6'h00, 72'h0, 8'hff);
    endtask
    task automatic do_reset(input logic strap);
        @(negedge clock);
        rst_n = 1'b0;
        term_sel = strap;
        exp_at.delete();
        last_rd = 1'b0;
        last_wr = 1'b0;
        imp_last = 0;
        imp_seen = 0;
        repeat (3) @(posedge link_clk);
        chk("oe rst", {read_data_oe, read_valid_flag}, 2'h0);
        @(negedge clock);
        rst_n = 1'b1;
        repeat (10) @(posedge clock);
        chk("range", termination_high_range, strap);
        $display("reset with strap %0d done", strap);
    endtask
    task automatic t_basic;
        req(1'b0, 1'b1, 6'h05, 72'h123456789abcdef012, 8'h00);
        req(1'b1, 1'b0, 6'h05, 72'h0, 8'hff);
        gap(1);
        req(1'b1, 1'b0, 6'h05, 72'h0, 8'hff);
        gap(1);
        req(1'b1, 1'b0, 6'h05, 72'h0, 8'hff);
        gap(6);
        $display("t_basic done");
    endtask
    task automatic t_mask;
        req(1'b0, 1'b1, 6'h09, 72'hfedcba98765432100f, 8'h00);
        gap(1);
        req(1'b0, 1'b1, 6'h09, 72'h0a1b2c3d4e5f607182, 8'h96);
        gap(1);
        req(1'b1, 1'b0, 6'h09, 72'h0, 8'hff);
        gap(6);
        $display("t_mask done");
    endtask
    task automatic t_drop;
        req(1'b1, 1'b0, 6'h05, 72'h0, 8'hff);
        req(1'b1, 1'b0, 6'h09, 72'h0, 8'hff);
        gap(4);
        req(1'b0, 1'b1, 6'h09, 72'h5a5a5a5a5a5a5a5a5a, 8'h00);
        req(1'b0, 1'b1, 6'h09, 72'ha5a5a5a5a5a5a5a5a5, 8'h00);
        gap(1);
        req(1'b1, 1'b0, 6'h09, 72'h0, 8'hff);
        gap(6);
        $display("t_drop done");
    endtask
    task automatic t_both;
        req(1'b0, 1'b1, 6'h0c, 72'h111122223333444455, 8'h00);
        gap(2);
        req(1'b1, 1'b1, 6'h0c, 72'h0, 8'hff);
        req(1'b1, 1'b1, 6'h0c, 72'h66667777888899990a, 8'h00);
        req(1'b1, 1'b1, 6'h0c, 72'h0, 8'hff);
        req(1'b1, 1'b1, 6'h0c, 72'h0bb0cc0dd0ee0ff011, 8'h00);
        gap(1);
        req(1'b1, 1'b0, 6'h0c, 72'h0, 8'hff);
        gap(6);
        $display("t_both done");
    endtask
    task automatic t_lock;
        for (int i = 0; i < 400 && loop_locked !== 1'b1; i++) @(posedge clock);
        chk("lock", loop_locked, 1'b1);
        @(negedge link_clk);
        link_run = 1'b0;
        #400;
        chk("lock stop", loop_locked, 1'b0);
        link_run = 1'b1;
        for (int i = 0; i < 400 && loop_locked !== 1'b1; i++) @(posedge clock);
        chk("relock", loop_locked, 1'b1);
        $display("t_lock done");
    endtask
    task automatic t_bypass;
        @(negedge clock);
        loop_bypass_n = 1'b0;
        gap(4);
        lat = 2;
        chk("lock off", loop_locked, 1'b0);
        req(1'b0, 1'b1, 6'h14, 72'h2468ace013579bdf02, 8'h00);
        gap(1);
        req(1'b1, 1'b0, 6'h14, 72'h0, 8'hff);
        gap(6);
        @(negedge clock);
        loop_bypass_n = 1'b1;
        lat = 5;
        gap(4);
        $display("t_bypass done");
    endtask
    task automatic t_imp;
        for (int i = 0; i < 4400 && imp_seen < 2; i++) @(posedge link_clk);
        chk("imp pulses", imp_seen >= 2, 1'b1);
        $display("t_imp done");
    endtask
    // Whole run stays near 330 us of link traffic
    initial begin
        #480000;
        n_mismatch++;
        $display("BAD watchdog expected done seen timeout");
        report_and_stop();
    end
    initial begin
        do_reset(1'b0);
        do_reset(1'b1);
        t_basic();
        t_mask();
        t_drop();
        t_both();
        t_lock();
        t_bypass();
        t_imp();
        report_and_stop();
    end
endmodule // tb_top
